// ### fsl_chk_asserts.sv
// Purpose: concurrent checks on the lamp outputs
// Assumes: tick_cyc_p of two or more
// Notes:   waits for the synchroniser to fill after reset
`timescale 1ns/1ns
module fsl_chk
#(
  parameter integer tick_cyc_p = 4
)
(
  input wire clk_sys_i,
  input wire rst_i,
  input wire link_connecting_i,
  input wire link_up_i,
  input wire online_i,
  input wire offline_i,
  input wire cfg_err_i,
  input wire prm_err_i,
  input wire init_fail_i,
  input wire diag_en_i,
  input wire link_state_lamp_o,
  input wire online_lamp_o,
  input wire offline_fault_lamp_o
);
  reg  [1:0] up_ff;
  wire       ok = &up_ff;
  wire       quiet = diag_en_i & offline_i &
                     ~(cfg_err_i | prm_err_i | init_fail_i);
  always @(posedge clk_sys_i or posedge rst_i)
    if (rst_i)
      up_ff <= 2'h0;
    else if (!ok)
      up_ff <= up_ff + 2'h1;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  AST_RESET_DARK: assert property ($fell(rst_i) |->
    !(link_state_lamp_o | online_lamp_o | offline_fault_lamp_o))
    else $error("dark");
  AST_ONLINE_ON: assert property (ok && $past(online_i, 3) |->
    online_lamp_o) else $error("online dark");
  AST_ONLINE_OFF: assert property (ok && !$past(online_i, 3) |->
    !online_lamp_o) else $error("online lit");
  AST_LINK_STEADY: assert property (ok && $past(link_connecting_i, 3) &&
    !$past(link_up_i, 3) |-> link_state_lamp_o) else $error("link dark");
  AST_LINK_OFF: assert property (ok && !$past(link_connecting_i, 3) &&
    !$past(link_up_i, 3) |-> !link_state_lamp_o) else $error("link lit");
  AST_LINK_BLINK: assert property (ok && $past(link_up_i, 4) &&
    $past(link_up_i, 3) && $past(link_up_i, 2) &&
    $changed(link_state_lamp_o) |=> $stable(link_state_lamp_o))
    else $error("link blink");
  AST_DIAG_OFF: assert property (ok && !$past(diag_en_i, 3) |->
    !offline_fault_lamp_o) else $error("fault lit");
  AST_FAULT_STEADY: assert property (ok && $past(quiet, 3) |->
    offline_fault_lamp_o) else $error("fault dark");
endmodule
bind fsl_status_lamps fsl_chk #(.tick_cyc_p(tick_cyc_p)) fsl_chk_inst (
  .clk_sys_i, .rst_i, .link_connecting_i, .link_up_i, .online_i,
  .offline_i, .cfg_err_i, .prm_err_i, .init_fail_i, .diag_en_i,
  .link_state_lamp_o, .online_lamp_o, .offline_fault_lamp_o);

// ### fsl_defines.vh
// Purpose: shared constants for the fieldbus card status lamps
// Assumes: system clock of 10 MHz
// Notes:   times in ns, cycle counts derived from them
`ifndef FSL_DEFINES_VH
`define FSL_DEFINES_VH

`define FSL_CLK_PERIOD_NS  100
// half period of the fastest (4 hz) pattern
`define FSL_TICK_NS        125000000
`define FSL_TICK_CYC       (`FSL_TICK_NS / `FSL_CLK_PERIOD_NS)
`define FSL_TICK_CNT_W     21
`define FSL_PHASE_W        3
// phase bit carrying each blink rate
`define FSL_PH_4HZ         0
`define FSL_PH_2HZ         1
`define FSL_PH_1HZ         2
`define FSL_SYNC_W         8

`endif

// ### fsl_far_side.sv
// Purpose: far side setting card conditions
// Assumes: conditions are levels
// Notes:   changes only on the falling edge
`timescale 1ns/1ns
module fsl_far_side
(
  input  wire       clk_sys_i,
  input  wire [7:0] want_i,
  output reg  [7:0] cond_o
);
  initial cond_o = 8'h00;
  always @(negedge clk_sys_i)
    cond_o <= want_i;
endmodule

// ### fsl_status_lamps.v
// Purpose: drive link, online and offline/fault lamps of a fieldbus card
// Assumes: condition inputs are asynchronous and pass two flip-flops
// Notes:   lamp outputs are high for lit and come from flip-flops
`timescale 1ns/1ns
`include "fsl_defines.vh"
module fsl_status_lamps
#(
  parameter integer tick_cyc_p = `FSL_TICK_CYC
)
(
  input  wire clk_sys_i,
  input  wire rst_i,
  input  wire link_connecting_i,
  input  wire link_up_i,
  input  wire online_i,
  input  wire offline_i,
  input  wire cfg_err_i,
  input  wire prm_err_i,
  input  wire init_fail_i,
  input  wire diag_en_i,
  output wire link_state_lamp_o,
  output wire online_lamp_o,
  output wire offline_fault_lamp_o
);
  wire [`FSL_SYNC_W-1:0]  raw;
  reg  [`FSL_SYNC_W-1:0]  meta_ff;
  reg  [`FSL_SYNC_W-1:0]  sync_ff;
  wire [`FSL_PHASE_W-1:0] phase;
  reg                     link_lamp_ff;
  reg                     online_lamp_ff;
  reg                     fault_lamp_ff;
  reg  [1:0]              link_state;
  reg  [2:0]              fault_cause;
  reg  [2:0]              link_pat;
  reg  [2:0]              fault_pat;
  reg  [2:0]              online_pat;
  wire [8:0]              lamp_pat;
  wire [2:0]              nxt_lamp;
  wire                    s_connecting;
  wire                    s_link_up;
  wire                    s_online;
  wire                    s_offline;
  wire                    s_cfg_err;
  wire                    s_prm_err;
  wire                    s_init_fail;
  wire                    s_diag_en;
  genvar                  gi;
  genvar                  gl;

  localparam [1:0] link_down     = 2'h0;
  localparam [1:0] link_conn     = 2'h1;
  localparam [1:0] link_est      = 2'h2;

  localparam [2:0] cause_none    = 3'h0;
  localparam [2:0] cause_chip    = 3'h1;
  localparam [2:0] cause_prm     = 3'h2;
  localparam [2:0] cause_cfg     = 3'h3;
  localparam [2:0] cause_offline = 3'h4;
  localparam [2:0] cause_muted   = 3'h5;

  localparam [2:0] pat_dark      = 3'h0;
  localparam [2:0] pat_steady    = 3'h1;
  localparam [2:0] pat_1hz       = 3'h2;
  localparam [2:0] pat_2hz       = 3'h3;
  localparam [2:0] pat_4hz       = 3'h4;

  assign raw = {diag_en_i, init_fail_i, prm_err_i, cfg_err_i,
                offline_i, online_i, link_up_i, link_connecting_i};

  // two-stage synchroniser per condition bit
  generate
    for (gi = 0; gi < `FSL_SYNC_W; gi = gi + 1)
    begin : g_sync
      always @(posedge clk_sys_i or posedge rst_i)
      begin
        if (rst_i)
        begin
          meta_ff[gi] <= 1'b0;
          sync_ff[gi] <= 1'b0;
        end
        else
        begin
          meta_ff[gi] <= raw[gi];
          sync_ff[gi] <= meta_ff[gi];
        end
      end
    end
  endgenerate

  assign s_connecting = sync_ff[0];
  assign s_link_up    = sync_ff[1];
  assign s_online     = sync_ff[2];
  assign s_offline    = sync_ff[3];
  assign s_cfg_err    = sync_ff[4];
  assign s_prm_err    = sync_ff[5];
  assign s_init_fail  = sync_ff[6];
  assign s_diag_en    = sync_ff[7];

  fsl_timebase
  #(
    .tick_cyc_p (tick_cyc_p)
  )
  u_timebase
  (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .phase_o   (phase)
  );

  // established link wins if both link inputs are seen together
  always @*
  begin
    if (s_link_up)
    begin
      link_state = link_est;
    end
    else if (s_connecting)
    begin
      link_state = link_conn;
    end
    else
    begin
      link_state = link_down;
    end
  end

  always @*
  begin
    case (link_state)
      link_est:
      begin
        link_pat = pat_1hz;
      end
      link_conn:
      begin
        link_pat = pat_steady;
      end
      link_down:
      begin
        link_pat = pat_dark;
      end
      default:
      begin
        link_pat = pat_dark;
      end
    endcase
  end

  always @*
  begin
    if (s_online)
    begin
      online_pat = pat_steady;
    end
    else
    begin
      online_pat = pat_dark;
    end
  end

  // a muted lamp hides every fault, so it is tested first
  // cause and pattern kept apart so a new source touches one table
  always @*
  begin
    if (!s_diag_en)
    begin
      fault_cause = cause_muted;
    end
    else if (s_init_fail)
    begin
      fault_cause = cause_chip;
    end
    else if (s_prm_err)
    begin
      fault_cause = cause_prm;
    end
    else if (s_cfg_err)
    begin
      fault_cause = cause_cfg;
    end
    else if (s_offline)
    begin
      fault_cause = cause_offline;
    end
    else
    begin
      fault_cause = cause_none;
    end
  end

  always @*
  begin
    case (fault_cause)
      cause_muted:
      begin
        fault_pat = pat_dark;
      end
      cause_chip:
      begin
        fault_pat = pat_4hz;
      end
      cause_prm:
      begin
        fault_pat = pat_2hz;
      end
      cause_cfg:
      begin
        fault_pat = pat_1hz;
      end
      cause_offline:
      begin
        fault_pat = pat_steady;
      end
      cause_none:
      begin
        // slow blink at the same 1 hz rate as a configuration fault (cause_cfg)
        fault_pat = pat_1hz;
      end
      default:
      begin
        fault_pat = pat_dark;
      end
    endcase
  end

  assign lamp_pat = {fault_pat,
                     online_pat,
                     link_pat};

  // one decoder per lamp; every rate taps the same phase counter
  generate
    for (gl = 0; gl < 3; gl = gl + 1)
    begin : g_lamp
      reg lvl;

      always @*
      begin
        case (lamp_pat[3*gl+:3])
          pat_steady:
          begin
            lvl = 1'b1;
          end
          pat_1hz:
          begin
            lvl = phase[`FSL_PH_1HZ];
          end
          pat_2hz:
          begin
            lvl = phase[`FSL_PH_2HZ];
          end
          pat_4hz:
          begin
            lvl = phase[`FSL_PH_4HZ];
          end
          pat_dark:
          begin
            lvl = 1'b0;
          end
          default:
          begin
            lvl = 1'b0;
          end
        endcase
      end
      assign nxt_lamp[gl] = lvl;
    end
  endgenerate

  always @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      link_lamp_ff   <= 1'b0;
      online_lamp_ff <= 1'b0;
      fault_lamp_ff  <= 1'b0;
    end
    else
    begin
      link_lamp_ff   <= nxt_lamp[0];
      online_lamp_ff <= nxt_lamp[1];
      fault_lamp_ff  <= nxt_lamp[2];
    end
  end

  assign link_state_lamp_o    = link_lamp_ff;
  assign online_lamp_o        = online_lamp_ff;
  assign offline_fault_lamp_o = fault_lamp_ff;
endmodule

// ### fsl_timebase.v
// Purpose: free-running blink timebase for the status lamps
// Assumes: tick_cyc_p cycles per 125 ms slot
// Notes:   one counter feeds every rate so all patterns stay in phase
`timescale 1ns/1ns
`include "fsl_defines.vh"
module fsl_timebase
#(
  parameter integer tick_cyc_p = `FSL_TICK_CYC
)
(
  input  wire                    clk_sys_i,
  input  wire                    rst_i,
  output wire [`FSL_PHASE_W-1:0] phase_o
);
  localparam integer               tick_last_i = tick_cyc_p - 1;
  localparam [`FSL_TICK_CNT_W-1:0] tick_last   =
    tick_last_i[`FSL_TICK_CNT_W-1:0];

  reg  [`FSL_TICK_CNT_W-1:0] cnt_ff;
  reg  [`FSL_PHASE_W-1:0]    phase_ff;
  wire                       wrap;

  assign wrap    = (cnt_ff == tick_last);
  assign phase_o = phase_ff;

  always @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cnt_ff   <= {`FSL_TICK_CNT_W{1'b0}};
      phase_ff <= {`FSL_PHASE_W{1'b0}};
    end
    else
    begin
      // phase bit n toggles every 2^n slots: 4, 2, 1 hz square waves
      cnt_ff <= wrap ? {`FSL_TICK_CNT_W{1'b0}} : cnt_ff + 1'b1;
      if (wrap)
      begin
        phase_ff <= phase_ff + 1'b1;
      end
    end
  end
endmodule

// ### test_fsl_status_lamps.sv
// Purpose: random and corner lamp patterns
// Assumes: slot of 8 cycles, so 1 hz is 64 cycles
// Notes:   windows of full periods make counts phase free
`timescale 1ns/1ns
module test_fsl_status_lamps;
  reg        clk_sys_i = 1'b0;
  reg        rst_i = 1'b1;
  reg  [7:0] want = 8'h00;
  reg [15:0] seed = 16'h50c1;
  wire [7:0] c;
  wire [2:0] lamp;
  integer    mismatches = 0;
  integer    tests_run = 0;
  integer    i;
  localparam [47:0] corner = 48'h82_88_91_78_b0_ff;
  always #50 clk_sys_i = ~clk_sys_i;
  fsl_far_side fsl_far_side_inst (.clk_sys_i(clk_sys_i), .want_i(want),
    .cond_o(c));
  fsl_status_lamps #(.tick_cyc_p(8)) fsl_status_lamps_inst (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .link_connecting_i(c[0]),
    .link_up_i(c[1]), .online_i(c[2]), .offline_i(c[3]), .cfg_err_i(c[4]),
    .prm_err_i(c[5]), .init_fail_i(c[6]), .diag_en_i(c[7]),
    .link_state_lamp_o(lamp[0]), .online_lamp_o(lamp[1]),
    .offline_fault_lamp_o(lamp[2]));
  function [15:0] xs(input [15:0] x);
    reg [15:0] y;
    begin
      y = x ^ (x << 7);
      y = y ^ (y >> 9);
      xs = y ^ (y << 8);
    end
  endfunction
  // codes: 0 dark, 1 steady, 2 1 hz, 3 2 hz, 4 4 hz
  function [8:0] exp_codes(input [7:0] v);
    exp_codes = {!v[7] ? 3'h0 : v[6] ? 3'h4 : v[5] ? 3'h3 : v[4] ? 3'h2 :
      v[3] ? 3'h1 : 3'h2, 2'h0, v[2], v[1] ? 3'h2 : {2'h0, v[0]}};
  endfunction
  function [2:0] code(input integer l, input integer t);
    code = t == 0 ? (l == 64 ? 3'h1 : l == 0 ? 3'h0 : 3'h7) : l != 32 ?
      3'h7 : t == 2 ? 3'h2 : t == 4 ? 3'h3 : t == 8 ? 3'h4 : 3'h7;
  endfunction
  task chk(input [8:0] g, input [8:0] e);
  begin
    tests_run = tests_run + 1;
    if (g !== e)
    begin
      mismatches = mismatches + 1;
      $display("[FAIL] %0t lamps %h want %h", $time, g, e);
    end
  end
  endtask
  task run_case(input [7:0] v);
    reg [8:0] got;
    reg       p;
    integer   k, l, t;
    begin
      want <= v;
      repeat (6) @(negedge clk_sys_i);
      for (k = 0; k < 3; k = k + 1)
      begin
        l = 0;
        t = 0;
        p = lamp[k];
        repeat (64)
        begin
          @(negedge clk_sys_i);
          l = l + lamp[k];
          t = t + (lamp[k] != p);
          p = lamp[k];
        end
        got[3*k+:3] = code(l, t);
      end
      chk(got, exp_codes(v));
      $display("case %h done", v);
    end
  endtask
  task print_verdict;
  begin
    $display("compares %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  end
  endtask
  initial
  begin
    repeat (3) @(negedge clk_sys_i);
    rst_i = 1'b0;
    for (i = 0; i < 20; i = i + 1)
    begin
      seed = xs(seed);
      run_case(i < 6 ? corner[8*i+:8] : seed[7:0]);
    end
    print_verdict;
  end
  initial
  begin
    #1000000;
    mismatches = mismatches + 1;
    print_verdict;
  end
endmodule
